// >>> tdm_top.sv
// timer dma request, mask clearing and arbitration logic
`timescale 1ns/1ps
`default_nettype none
`include "tdm_map.svh"
module tdm_top #(
    parameter int CNT_W = `TDM_CNT_WIDTH,
    parameter int PRIO_W = `TDM_PRIO_WIDTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [1:0] capture_event,
    input wire logic [1:0] compare_event,
    input wire logic [1:0] mask_set_cap,
    input wire logic [1:0] mask_set_cmp,
    input wire logic [1:0] flag_clr_cap,
    input wire logic [1:0] flag_clr_cmp,
    input wire logic [1:0] cnt_load,
    input wire logic [CNT_W-1:0] cnt_load_value,
    input wire logic serial_req,
    input wire logic serial_last,
    input wire logic i2c_req,
    input wire logic i2c_last,
    input wire logic top_irq,
    input wire logic [PRIO_W-1:0] prio_a,
    input wire logic [PRIO_W-1:0] prio_b,
    input wire logic [PRIO_W-1:0] prio_ser,
    input wire logic [PRIO_W-1:0] prio_i2c,
    output logic [7:0] interrupt_dma_mask_reg_a,
    output logic [7:0] interrupt_dma_mask_reg_b,
    output logic [7:0] timer_flag_reg_a,
    output logic [7:0] timer_flag_reg_b,
    output logic [CNT_W-1:0] dma_count_unit_a,
    output logic [CNT_W-1:0] dma_count_unit_b,
    output logic grant_valid,
    output var tdm_pkg::tdm_src_t grant_src,
    output logic block_complete_event,
    output logic [1:0] timer_irq
);
    import tdm_pkg::*;

    // refused at elaboration: a zero-width counter or priority cannot work
    if (CNT_W < 1 || PRIO_W < 1) begin : g_bad_width
        $error("tdm_top: bad widths");
    end

    // ****************************************
    // request and mask state
    // ****************************************
    logic [7:0] mask_reg [2];
    logic [7:0] flag_reg [2];
    logic [CNT_W-1:0] cnt_reg [2];
    logic [1:0] pend_reg [2];   // [1]=capture, [0]=compare pending dma
    logic [1:0] wrong_pend_reg; // unit b channels wrongly unmasked last cycle
    logic [1:0] irq_reg;
    logic grant_valid_reg;
    logic [1:0] last_src_reg;
    logic last_eob_reg;

    // dma enable per unit and channel
    wire cap_en_a = mask_reg[0][`TDM_CAP_MASK_BIT];
    wire cmp_en_a = mask_reg[0][`TDM_CMP_MASK_BIT];
    wire cap_en_b = mask_reg[1][`TDM_CAP_MASK_BIT];
    wire cmp_en_b = mask_reg[1][`TDM_CMP_MASK_BIT];
    // requests gated by mask; cleared mask stops new ones
    wire req_a = |pend_reg[0];
    wire req_b = |pend_reg[1];

    // ****************************************
    // arbitration
    // ****************************************
    // highest priority wins, ties to lower index; top irq blocks all
    logic [3:0] reqv;
    logic [PRIO_W-1:0] prv [4];
    assign reqv = {i2c_req, serial_req, req_b, req_a};
    assign prv[0] = prio_a;
    assign prv[1] = prio_b;
    assign prv[2] = prio_ser;
    assign prv[3] = prio_i2c;
    logic [1:0] win;
    logic any_req;
    always_comb begin
        win = 2'd0;
        any_req = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (reqv[i] && (!any_req || prv[i] > prv[win])) begin
                win = 2'(i);
                any_req = 1'b1;
            end
        end
    end
    wire do_grant = any_req && !top_irq;

    // completion of the granted transfer
    wire tim_win = do_grant && (win[1] == 1'b0);
    wire [CNT_W-1:0] cnt_win = cnt_reg[win[0]];
    wire tim_eob = tim_win && (cnt_win == CNT_W'(1));
    wire ext_eob = do_grant && ((win == 2'd2 && serial_last) || (win == 2'd3 && i2c_last));
    wire eob_now = tim_eob || ext_eob; // serial/i2c clear no mask of their own
    // defect window: unit b pending while a's completion served, a priority zero
    wire wrong_clr_b = tim_eob && win == 2'd0 && req_b && prio_a == '0;
    // serial/i2c completions also open the window on unit b
    wire wrong_clr_x = ext_eob && req_b && prio_a == '0;
    // a wrongly unmasked request gets one arbitration; losing it drops it
    wire b_wins = do_grant && win == 2'd1;
    wire [1:0] lost_b = b_wins ? 2'b00 : wrong_pend_reg;

    // ****************************************
    // per-unit update
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int u = 0; u < 2; u++) begin
                mask_reg[u] <= `TDM_MASK_RESET;
                flag_reg[u] <= `TDM_FLAG_RESET;
                cnt_reg[u] <= '0;
                pend_reg[u] <= 2'b00;
            end
            wrong_pend_reg <= 2'b00;
            irq_reg <= 2'b00;
        end else begin
            for (int u = 0; u < 2; u++) begin
                automatic logic granted = tim_win && win[0] == u[0];
                automatic logic cap_en = mask_reg[u][`TDM_CAP_MASK_BIT];
                automatic logic cmp_en = mask_reg[u][`TDM_CMP_MASK_BIT];
                automatic logic [1:0] served = 2'b00;
                automatic logic [1:0] clr = 2'b00;
                automatic logic [1:0] drop = (u == 1) ? lost_b : 2'b00;
                automatic logic cap_flag = (capture_event[u] & ~cap_en)
                    | (flag_reg[u][`TDM_CAP_MASK_BIT] & ~flag_clr_cap[u]);
                automatic logic cmp_flag = (compare_event[u] & ~cmp_en)
                    | (flag_reg[u][`TDM_FLAG_CMP_BIT] & ~flag_clr_cmp[u]);
                if (granted) begin
                    served = pend_reg[u][1] ? 2'b10 : 2'b01;
                    if (cnt_reg[u] == CNT_W'(1)) clr = served;
                end
                if (u == 1 && (wrong_clr_b || wrong_clr_x)) begin
                    clr = clr | pend_reg[1];
                end
                if (cnt_load[u]) cnt_reg[u] <= cnt_load_value;
                else if (granted && cnt_reg[u] != '0) cnt_reg[u] <= cnt_reg[u] - CNT_W'(1);
                // pending survives a wrong clear until granted or lost
                pend_reg[u][1] <= (pend_reg[u][1] & ~served[1] & ~drop[1])
                    | (capture_event[u] & cap_en);
                pend_reg[u][0] <= (pend_reg[u][0] & ~served[0] & ~drop[0])
                    | (compare_event[u] & cmp_en);
                // set wins over clear on every flag and mask
                mask_reg[u][`TDM_CAP_MASK_BIT] <= mask_set_cap[u] | (cap_en & ~clr[1]);
                mask_reg[u][`TDM_CMP_MASK_BIT] <= mask_set_cmp[u] | (cmp_en & ~clr[0]);
                flag_reg[u][`TDM_CAP_MASK_BIT] <= cap_flag;
                flag_reg[u][`TDM_FLAG_CMP_BIT] <= cmp_flag;
                irq_reg[u] <= cap_flag | cmp_flag;
            end
            // armed for the next arbitration only; preempted there, it is lost
            wrong_pend_reg <= (wrong_clr_b || wrong_clr_x) ? pend_reg[1] : 2'b00;
        end
    end

    // ****************************************
    // grant outputs
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            grant_valid_reg <= 1'b0;
            last_src_reg <= 2'd0;
            last_eob_reg <= 1'b0;
        end else begin
            grant_valid_reg <= do_grant;
            last_eob_reg <= eob_now;
            if (do_grant) last_src_reg <= win;
        end
    end

    assign interrupt_dma_mask_reg_a = mask_reg[0];
    assign interrupt_dma_mask_reg_b = mask_reg[1];
    assign timer_flag_reg_a = flag_reg[0];
    assign timer_flag_reg_b = flag_reg[1];
    assign dma_count_unit_a = cnt_reg[0];
    assign dma_count_unit_b = cnt_reg[1];
    assign grant_valid = grant_valid_reg;
    assign grant_src = tdm_src_t'(last_src_reg);
    assign block_complete_event = last_eob_reg;
    assign timer_irq = irq_reg;

    // ****************************************
    // checks
    // ****************************************
    a_mask_clears_eob: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tim_eob && win == 2'd0 && pend_reg[0] == 2'b01 && !mask_set_cmp[0])
        |=> !mask_reg[0][`TDM_CMP_MASK_BIT]) else $error("mask not cleared at end");
    a_wrong_clear_b: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wrong_clr_b && pend_reg[1][0] && !mask_set_cmp[1])
        |=> !mask_reg[1][`TDM_CMP_MASK_BIT]) else $error("unit b mask kept");
    a_no_req_masked: assert property (@(posedge ref_clk) disable iff (!resetn)
        (compare_event[1] && !cmp_en_b && !pend_reg[1][0]) |=> !pend_reg[1][0])
        else $error("request raised while masked");
    a_no_cap_masked: assert property (@(posedge ref_clk) disable iff (!resetn)
        (capture_event[0] && !cap_en_a && !pend_reg[0][1]) |=> !pend_reg[0][1])
        else $error("capture request raised while masked");
    a_irq_when_masked: assert property (@(posedge ref_clk) disable iff (!resetn)
        (compare_event[0] && !cmp_en_a) |=> timer_flag_reg_a[`TDM_FLAG_CMP_BIT])
        else $error("event not flagged");
    a_irq_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
        (compare_event[1] && !cmp_en_b) |=> timer_irq[1])
        else $error("interrupt not raised");
    a_irq_blocks_dma: assert property (@(posedge ref_clk) disable iff (!resetn)
        top_irq |=> !grant_valid) else $error("grant under top irq");
    a_cnt_decrements: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tim_win && win == 2'd1 && !cnt_load[1] && cnt_reg[1] != '0)
        |=> dma_count_unit_b == $past(cnt_reg[1]) - CNT_W'(1)) else $error("count");
    a_pending_served: assert property (@(posedge ref_clk) disable iff (!resetn)
        (do_grant && win == 2'd1) |=> grant_src == TDM_SRC_B) else $error("b not served");
    a_wrong_served: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wrong_pend_reg != 2'b00 && b_wins) |=> grant_valid && grant_src == TDM_SRC_B)
        else $error("wrongly unmasked request not served");
    a_lost_dropped: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wrong_pend_reg != 2'b00 && !b_wins && !capture_event[1] && !compare_event[1])
        |=> (pend_reg[1] & $past(wrong_pend_reg)) == 2'b00) else $error("lost request kept");
    a_ext_no_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ext_eob && !wrong_clr_x && cap_en_b && !tim_win) |=> cap_en_b)
        else $error("serial end cleared mask");
    a_mask_bit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        mask_set_cap[0] |=> cap_en_a) else $error("set lost");
    a_mask_bit_b: assert property (@(posedge ref_clk) disable iff (!resetn)
        mask_set_cmp[1] |=> cmp_en_b) else $error("set lost on unit b");
endmodule : tdm_top
`default_nettype wire

// >>> tdm_map.svh
// constants for the timer dma mask and block-complete block
// Contract
// - mask bits 6 and 3 select dma
// - transfer decrements counter, zero clears mask
// - unit b wrongly clears mask on a's completion while a's priority is zero
// - serial port and i2c clear no mask of their own, but their completions can wrongly clear unit b's
// - preempted wrongly unmasked request is lost
// - pending request still serviced if it wins
// - cleared mask stops further dma requests
// - cleared mask turns events into interrupts
`ifndef TDM_MAP_SVH
`define TDM_MAP_SVH
`define TDM_CAP_MASK_BIT 6
`define TDM_CMP_MASK_BIT 3
`define TDM_FLAG_CMP_BIT 5
`define TDM_MASK_RESET 8'h00
`define TDM_FLAG_RESET 8'h00
`define TDM_CNT_WIDTH 16
`define TDM_NUM_REQ 4
`define TDM_PRIO_WIDTH 3
`endif

// >>> tdm_pkg.sv
// types for the timer dma mask and block-complete block
package tdm_pkg;
    typedef enum logic [1:0] {
        TDM_IDLE,
        TDM_SERVE
    } tdm_state_t;
    // requester index: timers, serial port, i2c
    typedef enum logic [1:0] {
        TDM_SRC_A,
        TDM_SRC_B,
        TDM_SRC_SER,
        TDM_SRC_I2C
    } tdm_src_t;
endpackage : tdm_pkg

// >>> tdm_far_end.sv
// far-side serial requester model for the timer dma bench
`timescale 1ns/1ps
`default_nettype none
module tdm_far_end (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic grant_valid,
    input wire tdm_pkg::tdm_src_t grant_src,
    output logic serial_req,
    output logic serial_last
);
    import tdm_pkg::*;
    // ************
    // request hold
    // ************
    logic pend_reg;
    logic last_reg;
    // request is masked while its grant shows, so one transfer is never granted twice
    wire granted_ser = grant_valid && grant_src == TDM_SRC_SER;
    assign serial_req = pend_reg && !granted_ser;
    assign serial_last = last_reg && !granted_ser;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= 1'b0;
            last_reg <= 1'b0;
        end else if (go) begin
            pend_reg <= 1'b1;
            last_reg <= 1'b1;
        end else if (granted_ser) begin
            pend_reg <= 1'b0;
            last_reg <= 1'b0;
        end
    end
endmodule : tdm_far_end
`default_nettype wire

// >>> tb.sv
// self-checking bench for the timer dma mask block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tdm_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, top_irq = 1'b0, go = 1'b0, gv, bce, sreq, slast;
    logic [1:0] cap_ev = 2'h0, cmp_ev = 2'h0, set_cap = 2'h0, set_cmp = 2'h0, ld = 2'h0, irq;
    logic [1:0] clr_cap = 2'h0, clr_cmp = 2'h0;
    logic [15:0] ld_val = 16'h0000, cnt_a, cnt_b;
    logic [2:0] pa = 3'h0, pb = 3'h0, ps = 3'h0;
    logic [7:0] mask_a, mask_b, flag_a, flag_b;
    tdm_src_t gsrc;
    int error_cnt = 0, num_checks = 0, b0 = 0;
    int gcnt[4];
    tdm_top dut (.ref_clk(ref_clk), .resetn(resetn), .capture_event(cap_ev),
        .compare_event(cmp_ev), .mask_set_cap(set_cap), .mask_set_cmp(set_cmp),
        .flag_clr_cap(clr_cap), .flag_clr_cmp(clr_cmp), .cnt_load(ld), .cnt_load_value(ld_val),
        .serial_req(sreq), .serial_last(slast), .i2c_req(1'b0), .i2c_last(1'b0),
        .top_irq(top_irq), .prio_a(pa), .prio_b(pb), .prio_ser(ps), .prio_i2c(3'h0),
        .interrupt_dma_mask_reg_a(mask_a), .interrupt_dma_mask_reg_b(mask_b),
        .timer_flag_reg_a(flag_a), .timer_flag_reg_b(flag_b), .dma_count_unit_a(cnt_a),
        .dma_count_unit_b(cnt_b), .grant_valid(gv), .grant_src(gsrc),
        .block_complete_event(bce), .timer_irq(irq));
    tdm_far_end far (.ref_clk(ref_clk), .resetn(resetn), .go(go), .grant_valid(gv),
        .grant_src(gsrc), .serial_req(sreq), .serial_last(slast));
    // ***********
    // clock, logs
    // ***********
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (gv === 1'b1) gcnt[gsrc] <= gcnt[gsrc] + 1;
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic grant_is(input tdm_src_t s);
        chk("grant", {13'h0, 1'b1, s}, {13'h0, gv, gsrc});
    endtask : grant_is
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // ***********
    // tests
    // ***********
    initial begin
        #20000;
        error_cnt++;
        $display("watchdog expired");
        wrap_up();
    end
    initial begin
        step(2);
        resetn = 1'b1;
        chk("mask_a", 16'h0000, {8'h00, mask_a});
        set_cmp = 2'h1; set_cap = 2'h1; ld = 2'h1; ld_val = 16'h0002;
        step(1);
        set_cmp = 2'h0; set_cap = 2'h0; ld = 2'h0;
        chk("mask_a", 16'h0048, {8'h00, mask_a});
        for (int i = 0; i < 2; i++) begin
            cmp_ev = 2'h1;
            step(1);
            cmp_ev = 2'h0;
            step(1);
            grant_is(TDM_SRC_A);
            chk("block_done", 16'(i), {15'h0, bce});
        end
        chk("mask_a", 16'h0040, {8'h00, mask_a});
        cmp_ev = 2'h1; cap_ev = 2'h2;
        step(1);
        cmp_ev = 2'h0; cap_ev = 2'h0; b0 = gcnt[0]; // last grant counted by now
        step(2);
        chk("no_req", 16'(b0), 16'(gcnt[0]));
        chk("flags", 16'h2040, {flag_a, flag_b});
        chk("irq", 16'h0003, {14'h0, irq});
        clr_cmp = 2'h1; set_cmp = 2'h1; clr_cap = 2'h2;
        step(1);
        clr_cmp = 2'h0; set_cmp = 2'h0; clr_cap = 2'h0;
        chk("restore", 16'h4800, {mask_a, flag_a});
        $display("test mask_and_complete done");
        top_irq = 1'b1; pa = 3'h2; pb = 3'h5; ld = 2'h3; ld_val = 16'h0003; set_cmp = 2'h2;
        step(1);
        ld = 2'h0; set_cmp = 2'h0; cmp_ev = 2'h3; b0 = gcnt[0] + gcnt[1];
        step(1);
        cmp_ev = 2'h0;
        step(3);
        chk("blocked", 16'(b0), 16'(gcnt[0] + gcnt[1]));
        top_irq = 1'b0;
        step(1);
        grant_is(TDM_SRC_B);
        step(1);
        grant_is(TDM_SRC_A);
        $display("test arbitration done");
        pa = 3'h0; pb = 3'h0; ld = 2'h1; ld_val = 16'h0001;
        step(1);
        ld = 2'h0; cmp_ev = 2'h3;
        step(1);
        cmp_ev = 2'h0;
        step(1);
        grant_is(TDM_SRC_A);
        chk("wrong_clear", 16'h0100, {7'h0, bce, mask_b});
        step(1);
        grant_is(TDM_SRC_B);
        chk("cnt_b", 16'h0001, cnt_b);
        $display("test wrong_clear done");
        top_irq = 1'b1; set_cmp = 2'h2; pb = 3'h1; ps = 3'h7;
        step(1);
        set_cmp = 2'h0; cmp_ev = 2'h2; go = 1'b1; b0 = gcnt[1];
        step(1);
        cmp_ev = 2'h0; go = 1'b0;
        step(2);
        top_irq = 1'b0;
        step(6);
        chk("mask_b", 16'h0000, {8'h00, mask_b});
        chk("b_served", 16'h0001, 16'(gcnt[1] - b0));
        $display("test serial_final done");
        pb = 3'h0; set_cmp = 2'h3; ld = 2'h3; ld_val = 16'h0001;
        step(1);
        set_cmp = 2'h0; ld = 2'h0; cmp_ev = 2'h3;
        step(1);
        cmp_ev = 2'h0; b0 = gcnt[1];
        step(1);
        top_irq = 1'b1;
        step(1);
        top_irq = 1'b0;
        step(3);
        chk("lost_b", 16'h0000, 16'(gcnt[1] - b0));
        chk("cnt_b_kept", 16'h0001, cnt_b);
        chk("mask_b_off", 16'h0000, {8'h00, mask_b});
        cmp_ev = 2'h2;
        step(1);
        cmp_ev = 2'h0;
        step(1);
        chk("flag_b", 16'h0020, {8'h00, flag_b});
        chk("irq_b", 16'h0002, {14'h0, irq});
        chk("no_dma_b", 16'h0000, 16'(gcnt[1] - b0));
        $display("test lost_transfer done");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
